//--- rtl/lfs_pkg.sv
// constants for the lock and fuse self-access block
package lfs_pkg;
   // register map
   localparam int unsigned  ADDR_W        = 6;
   localparam logic [5:0]   SPC_OFF       = 6'h00;
   localparam logic [5:0]   STAT_OFF      = 6'h01;
   // self_program_control fields
   localparam int unsigned  SPC_STORE_EN  = 0;
   localparam int unsigned  SPC_LOCK_SEL  = 3;
   localparam logic [6:0]   SPC_CMD_MASK  = 7'h7f;
   localparam logic [6:0]   SPC_CMD_LOCK  = 7'h09;
   localparam logic [7:0]   SPC_RST       = 8'h00;
   // z pointer selects for fuse and lock reads
   localparam logic [15:0]  Z_FUSE_LO     = 16'h0000;
   localparam logic [15:0]  Z_LOCK        = 16'h0001;
   localparam logic [15:0]  Z_FUSE_HI     = 16'h0003;
   localparam logic [7:0]   RD_UNMAPPED   = 8'hff;
   // source/lock byte layout
   localparam int unsigned  BOOT_LSB      = 2;
   localparam int unsigned  BOOT_W        = 4;
   localparam int unsigned  LOCK_W        = 6;
   // timed enable windows, in cycles after the control write
   localparam logic [2:0]   LOAD_WIN      = 3'd3;
   localparam logic [2:0]   STORE_WIN     = 3'd4;
   // write time from the calibrated oscillator
   localparam int unsigned  CLK_PERIOD_PS = 5000;
   localparam longint unsigned WR_MIN_PS  = 64'd3700000000;
   localparam longint unsigned WR_MAX_PS  = 64'd4500000000;
   localparam int unsigned  WR_CYC        = int'((WR_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam int unsigned  WR_MAX_CYC    = int'(WR_MAX_PS / CLK_PERIOD_PS);
   localparam int unsigned  TMR_W         = 20;
endpackage : lfs_pkg

//--- rtl/lfs_wr_timer.sv
// write duration timer, survives reset once running
`timescale 1ns/1ps
`default_nettype none
module lfs_wr_timer #(
   parameter int unsigned CYCLES = lfs_pkg::WR_CYC
) (
   input  wire logic CLK,
   input  wire logic RST,
   input  wire logic start,
   output logic      busy,
   output logic      done
);
   import lfs_pkg::*;

   typedef struct packed {
      logic             run;
      logic [TMR_W-1:0] cnt;
      logic             done;
   } lfs_tmr_t;

   lfs_tmr_t st_r;
   lfs_tmr_t st_nxt;

   always_comb begin
      st_nxt = '0;
      // a running or just started write is finished even through reset
      if (!RST || st_r.run || start) begin
         st_nxt      = st_r;
         st_nxt.done = 1'b0;
         if (st_r.run) begin
            if (st_r.cnt == TMR_W'(CYCLES - 1)) begin
               st_nxt.run  = 1'b0;
               st_nxt.done = 1'b1;
            end else begin
               st_nxt.cnt = st_r.cnt + TMR_W'(1);
            end
         end else if (start) begin
            st_nxt.run = 1'b1;
            st_nxt.cnt = '0;
         end
      end
   end

   always_ff @(posedge CLK) begin
      st_r <= st_nxt;
   end

   assign busy = st_r.run;
   assign done = st_r.done;
endmodule : lfs_wr_timer
`default_nettype wire

//--- rtl/lfs_top.sv
// lock and fuse self-access logic beside the processor core
// Contract
// - zero in source bits 5..2 programs that boot lock bit, store within four cycles
// - z pointer is ignored while boot lock bits are programmed
// - flash stays readable during lock programming; cpu never halted
// - eeprom write in progress blocks all flash programming
// - eeprom write in progress refuses fuse and lock reads
// - z 0001 load within three cycles returns lock bits
// - select and store enable clear after read or when windows expire
// - with both bits clear a load is an ordinary flash read
// - lock read: boot locks in 5..2, general locks in 1..0
// - z 0000 load returns fuse low byte in order 7..0
// - z 0003 load within three cycles returns fuse high byte
// - programmed bits read zero, unprogrammed read one
// - write in progress completes through reset
// - lock write timed 3.7 ms to 4.5 ms
// - general lock bits cannot be changed by this path
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module lfs_top #(
   parameter int unsigned WRITE_CYCLES = lfs_pkg::WR_CYC
) (
   input  wire logic                       CLK,
   input  wire logic                       RST,
   // register port
   input  wire logic [lfs_pkg::ADDR_W-1:0] REG_ADDR,
   input  wire logic [7:0]                 REG_WDATA,
   input  wire logic                       REG_WR,
   input  wire logic                       REG_RD,
   output logic      [7:0]                 REG_RDATA,
   // load program instruction port
   input  wire logic                       LOAD_REQ,
   input  wire logic [15:0]                LOAD_Z,
   input  wire logic [7:0]                 FLASH_RDATA,
   output logic                            LOAD_VALID,
   output logic      [7:0]                 LOAD_DATA,
   // store program instruction port
   input  wire logic                       STORE_REQ,
   input  wire logic [7:0]                 STORE_SRC,
   // eeprom writer interlock
   input  wire logic                       EEPROM_WRITE_BUSY,
   // nonvolatile bits, zero means programmed
   input  wire logic [lfs_pkg::LOCK_W-1:0] NV_LOCK,
   input  wire logic [7:0]                 NV_FUSE_LOW_BYTE,
   input  wire logic [7:0]                 NV_FUSE_HIGH_BYTE,
   output logic                            NV_LOCK_WE,
   output logic      [lfs_pkg::LOCK_W-1:0] NV_LOCK_WDATA,
   output logic                            LOCK_WRITE_BUSY,
   output logic                            CPU_HALT
);
   import lfs_pkg::*;

   typedef struct packed {
      logic              lock_access_select;
      logic              store_enable;
      logic [2:0]        win;
      logic              writing;
      logic [BOOT_W-1:0] prog_mask;
      logic              tmr_start;
      logic [7:0]        rdata;
      logic              load_valid;
      logic [7:0]        load_data;
      logic              nv_we;
      logic [LOCK_W-1:0] nv_wdata;
   } lfs_state_t;

   lfs_state_t st_r;
   lfs_state_t st_nxt;

   logic       tmr_busy;
   logic       tmr_done;

   // selects the nonvolatile byte for a timed load
   function automatic logic [7:0] nv_byte(input logic [15:0]       z,
                                          input logic [LOCK_W-1:0] lock,
                                          input logic [7:0]        flo,
                                          input logic [7:0]        fhi);
      logic [7:0] r;
      r = RD_UNMAPPED;
      unique case (z)
         Z_LOCK:    r = {2'b11, lock};
         Z_FUSE_LO: r = flo;
         Z_FUSE_HI: r = fhi;
         default:   r = RD_UNMAPPED;
      endcase
      return r;
   endfunction : nv_byte

   // control register view
   function automatic logic [7:0] spc_view(input logic sel,
                                           input logic sen);
      logic [7:0] v;
      v               = SPC_RST;
      v[SPC_LOCK_SEL] = sel;
      v[SPC_STORE_EN] = sen;
      return v;
   endfunction : spc_view

   lfs_wr_timer #(
      .CYCLES (WRITE_CYCLES)
   ) u_tmr (
      .CLK   (CLK),
      .RST   (RST),
      .start (st_r.tmr_start),
      .busy  (tmr_busy),
      .done  (tmr_done)
   );

   logic armed;
   logic cmd_ok;
   logic in_load_win;
   logic in_store_win;

   always_comb begin
      armed        = st_r.lock_access_select && st_r.store_enable && !st_r.writing && !tmr_busy;
      cmd_ok       = (REG_WDATA[6:0] & SPC_CMD_MASK) == SPC_CMD_LOCK;
      in_load_win  = armed && (st_r.win != 3'd0) && (st_r.win <= LOAD_WIN);
      in_store_win = armed && (st_r.win != 3'd0) && (st_r.win <= STORE_WIN);

      st_nxt            = st_r;
      st_nxt.tmr_start  = 1'b0;
      st_nxt.load_valid = 1'b0;
      st_nxt.nv_we      = 1'b0;
      st_nxt.rdata      = 8'h00;

      // window ages each cycle; expiry drops both bits
      if (armed) begin
         if (st_r.win >= STORE_WIN) begin
            st_nxt.lock_access_select = 1'b0;
            st_nxt.store_enable       = 1'b0;
            st_nxt.win                = 3'd0;
         end else begin
            st_nxt.win = st_r.win + 3'd1;
         end
      end

      // loads: timed fuse or lock read, else ordinary flash read
      if (LOAD_REQ) begin
         st_nxt.load_valid = 1'b1;
         if (in_load_win && !EEPROM_WRITE_BUSY) begin
            st_nxt.load_data          = nv_byte(LOAD_Z, NV_LOCK, NV_FUSE_LOW_BYTE,
                                                NV_FUSE_HIGH_BYTE);
            st_nxt.lock_access_select = 1'b0;
            st_nxt.store_enable       = 1'b0;
            st_nxt.win                = 3'd0;
         end else begin
            // reads proceed even while a lock write runs
            st_nxt.load_data = FLASH_RDATA;
         end
      end

      // store: program boot lock bits, z pointer not looked at
      if (STORE_REQ && in_store_win && !EEPROM_WRITE_BUSY) begin
         st_nxt.writing   = 1'b1;
         st_nxt.prog_mask = ~STORE_SRC[BOOT_LSB +: BOOT_W];
         st_nxt.tmr_start = 1'b1;
         st_nxt.win       = 3'd0;
      end

      // end of timed write: commit and release store enable in the same cycle
      if (st_r.writing && tmr_done) begin
         st_nxt.writing                     = 1'b0;
         st_nxt.store_enable                = 1'b0;
         st_nxt.lock_access_select          = 1'b0;
         st_nxt.nv_we                       = 1'b1;
         st_nxt.nv_wdata                    = NV_LOCK;
         // only clearing bits programs; general locks kept as read
         st_nxt.nv_wdata[BOOT_LSB +: BOOT_W] = NV_LOCK[BOOT_LSB +: BOOT_W] & ~st_r.prog_mask;
      end

      // control register write, refused while eeprom or lock write busy
      if (REG_WR && REG_ADDR == SPC_OFF && !EEPROM_WRITE_BUSY && !st_r.writing) begin
         if (cmd_ok) begin
            st_nxt.lock_access_select = 1'b1;
            st_nxt.store_enable       = 1'b1;
            st_nxt.win                = 3'd1;
         end else begin
            // other commands belong to the page logic; drop ours
            st_nxt.lock_access_select = 1'b0;
            st_nxt.store_enable       = 1'b0;
            st_nxt.win                = 3'd0;
         end
      end

      // register reads, data one cycle later
      if (REG_RD) begin
         unique case (REG_ADDR)
            SPC_OFF:  st_nxt.rdata = spc_view(st_r.lock_access_select,
                                              st_r.store_enable);
            STAT_OFF: st_nxt.rdata = {6'h00, EEPROM_WRITE_BUSY, st_r.writing};
            default:  st_nxt.rdata = 8'h00;
         endcase
      end

      // reset clears all state, but while a write runs only the read outputs clear and the write keeps going
      if (RST) begin
         if (st_r.writing) begin
            st_nxt.rdata      = 8'h00;
            st_nxt.load_valid = 1'b0;
            st_nxt.load_data  = 8'h00;
         end else begin
            st_nxt = '0;
         end
      end
   end

   always_ff @(posedge CLK) begin
      st_r <= st_nxt;
   end

   assign REG_RDATA       = st_r.rdata;
   assign LOAD_VALID      = st_r.load_valid;
   assign LOAD_DATA       = st_r.load_data;
   assign NV_LOCK_WE      = st_r.nv_we;
   assign NV_LOCK_WDATA   = st_r.nv_wdata;
   assign LOCK_WRITE_BUSY = st_r.writing;
   // lock programming never stalls the core
   assign CPU_HALT        = 1'b0;
endmodule : lfs_top
`default_nettype wire

//--- dv/lfs_nv_model.sv
// far side model: lock and fuse array plus flash bytes
`timescale 1ns/1ps
`default_nettype none
module lfs_nv_model #(
   parameter logic [5:0] LOCK_INIT = 6'h3f,
   parameter logic [7:0] FUSE_LO   = 8'h3c,
   parameter logic [7:0] FUSE_HI   = 8'hc9
) (
   input  wire logic        CLK,
   input  wire logic [15:0] load_z,
   input  wire logic        lock_we,
   input  wire logic [5:0]  lock_wdata,
   output logic      [5:0]  lock_bits,
   output logic      [7:0]  fuse_lo,
   output logic      [7:0]  fuse_hi,
   output logic      [7:0]  flash
);
   // nonvolatile, so no reset: contents survive a system reset
   logic [5:0] lock_r = LOCK_INIT;
   always_ff @(posedge CLK) begin
      if (lock_we) lock_r <= lock_wdata;
   end
   assign lock_bits = lock_r;
   assign fuse_lo   = FUSE_LO;
   assign fuse_hi   = FUSE_HI;
   // address-dependent pattern so a stale byte never matches
   assign flash     = load_z[7:0] ^ 8'ha5;
endmodule : lfs_nv_model
`default_nettype wire

//--- dv/lfs_assertions.sv
// timing checks on the lock and fuse self-access ports
`timescale 1ns/1ps
`default_nettype none
module lfs_assertions import lfs_pkg::*; #(
   parameter int unsigned WRITE_CYCLES = 20
) (
   input wire logic CLK, RST, REG_WR, REG_RD, LOAD_REQ, STORE_REQ, EEPROM_WRITE_BUSY,
   input wire logic LOAD_VALID, NV_LOCK_WE, LOCK_WRITE_BUSY, CPU_HALT,
   input wire logic [lfs_pkg::ADDR_W-1:0] REG_ADDR,
   input wire logic [7:0]  REG_WDATA, REG_RDATA, FLASH_RDATA, LOAD_DATA, STORE_SRC,
   input wire logic [7:0]  NV_FUSE_LOW_BYTE, NV_FUSE_HIGH_BYTE,
   input wire logic [15:0] LOAD_Z,
   input wire logic [lfs_pkg::LOCK_W-1:0] NV_LOCK, NV_LOCK_WDATA
);
   // timer start edge plus commit edge after the counted cycles
   localparam int WB_DLY = WRITE_CYCLES + 2;
   logic [2:0] age_r, age_nxt;
   logic [7:0] src_r, src_nxt;
   logic       arm, tld, tst;
   // age counts cycles since the arming write, 0 when not armed
   assign arm = REG_WR && REG_ADDR == SPC_OFF && REG_WDATA[6:0] == SPC_CMD_LOCK
                && !EEPROM_WRITE_BUSY && !LOCK_WRITE_BUSY;
   assign tld = LOAD_REQ && age_r inside {[3'd1:LOAD_WIN]} && !EEPROM_WRITE_BUSY;
   assign tst = STORE_REQ && age_r inside {[3'd1:STORE_WIN]} && !EEPROM_WRITE_BUSY
                && !LOCK_WRITE_BUSY;
   always_comb begin
      age_nxt = (age_r == 3'd0 || age_r == STORE_WIN) ? 3'd0 : age_r + 3'd1;
      if (tld || tst || (REG_WR && REG_ADDR == SPC_OFF && !EEPROM_WRITE_BUSY
          && !LOCK_WRITE_BUSY)) age_nxt = 3'd0;
      if (arm) age_nxt = 3'd1;
      if (RST) age_nxt = 3'd0;
      src_nxt = tst ? STORE_SRC : src_r;
   end
   always_ff @(posedge CLK) begin
      age_r <= age_nxt;
      src_r <= src_nxt;
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   sequence s_store; tst; endsequence
   sequence s_write; LOCK_WRITE_BUSY ##WB_DLY NV_LOCK_WE; endsequence
   property p_no_halt; !CPU_HALT; endproperty
   a_no_halt: assert property (p_no_halt) else $error("core halted");
   property p_valid; LOAD_VALID == $past(LOAD_REQ); endproperty
   a_valid: assert property (p_valid) else $error("load valid misplaced");
   property p_lock_rd; tld && LOAD_Z == Z_LOCK |=> LOAD_DATA == {2'b11, $past(NV_LOCK)}; endproperty
   a_lock_rd: assert property (p_lock_rd) else $error("lock byte wrong");
   property p_fuse_lo; tld && LOAD_Z == Z_FUSE_LO |=> LOAD_DATA == $past(NV_FUSE_LOW_BYTE); endproperty
   a_fuse_lo: assert property (p_fuse_lo) else $error("fuse low wrong");
   property p_fuse_hi; tld && LOAD_Z == Z_FUSE_HI |=> LOAD_DATA == $past(NV_FUSE_HIGH_BYTE); endproperty
   a_fuse_hi: assert property (p_fuse_hi) else $error("fuse high wrong");
   property p_plain;
      LOAD_REQ && !tld |=> LOAD_DATA == $past(FLASH_RDATA);
   endproperty
   a_plain: assert property (p_plain) else $error("plain load wrong");
   property p_write; s_store |=> s_write; endproperty
   a_write: assert property (p_write) else $error("lock write timing wrong");
   property p_busy; s_store |=> LOCK_WRITE_BUSY [*8]; endproperty
   a_busy: assert property (p_busy) else $error("busy dropped early");
   property p_wdata; NV_LOCK_WE |-> NV_LOCK_WDATA == (NV_LOCK & {src_r[5:2], 2'b11}); endproperty
   a_wdata: assert property (p_wdata) else $error("lock data wrong");
   property p_refuse;
      STORE_REQ && (EEPROM_WRITE_BUSY || age_r == 3'd0) && !LOCK_WRITE_BUSY |=> !LOCK_WRITE_BUSY;
   endproperty
   a_refuse: assert property (p_refuse) else $error("store not refused");
   property p_rd_idle; !REG_RD |=> REG_RDATA == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
endmodule : lfs_assertions
`default_nettype wire

//--- dv/tb_top.sv
// self-checking bench for the lock and fuse self-access block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import lfs_pkg::*;
   localparam int unsigned WC = 20;
   localparam logic [7:0] FLO = 8'h3c, FHI = 8'hc9;
   typedef struct packed { logic t; logic [15:0] z; logic [7:0] e; } lfs_row_t;
   logic CLK = 0, RST = 1, REG_WR = 0, REG_RD = 0, LOAD_REQ = 0, STORE_REQ = 0;
   logic EEPROM_WRITE_BUSY = 0, LOAD_VALID, NV_LOCK_WE, LOCK_WRITE_BUSY, CPU_HALT;
   logic [5:0] REG_ADDR = '0, NV_LOCK, NV_LOCK_WDATA;
   logic [7:0] REG_WDATA = '0, STORE_SRC = '0, REG_RDATA, FLASH_RDATA, LOAD_DATA, d;
   logic [7:0] NV_FUSE_LOW_BYTE, NV_FUSE_HIGH_BYTE;
   logic [15:0] LOAD_Z = '0;
   int n_mismatch = 0, n_compared = 0, n;
   // timed rows arm first; unknown select reads ff, unarmed loads fall back to flash
   lfs_row_t rows [6] = '{'{1'b1, 16'h0001, 8'hff}, '{1'b1, 16'h0000, FLO},
      '{1'b1, 16'h0003, FHI}, '{1'b1, 16'h0002, 8'hff}, '{1'b0, 16'h0001, 8'ha4},
      '{1'b0, 16'h0003, 8'ha6}};
   lfs_top #(.WRITE_CYCLES(WC)) lfs_top_i (.CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR),
      .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
      .LOAD_REQ(LOAD_REQ), .LOAD_Z(LOAD_Z), .FLASH_RDATA(FLASH_RDATA),
      .LOAD_VALID(LOAD_VALID), .LOAD_DATA(LOAD_DATA), .STORE_REQ(STORE_REQ),
      .STORE_SRC(STORE_SRC), .EEPROM_WRITE_BUSY(EEPROM_WRITE_BUSY), .NV_LOCK(NV_LOCK),
      .NV_FUSE_LOW_BYTE(NV_FUSE_LOW_BYTE), .NV_FUSE_HIGH_BYTE(NV_FUSE_HIGH_BYTE),
      .NV_LOCK_WE(NV_LOCK_WE), .NV_LOCK_WDATA(NV_LOCK_WDATA),
      .LOCK_WRITE_BUSY(LOCK_WRITE_BUSY), .CPU_HALT(CPU_HALT));
   lfs_nv_model #(.FUSE_LO(FLO), .FUSE_HI(FHI)) lfs_nv_model_i (.CLK(CLK), .load_z(LOAD_Z),
      .lock_we(NV_LOCK_WE), .lock_wdata(NV_LOCK_WDATA), .lock_bits(NV_LOCK),
      .fuse_lo(NV_FUSE_LOW_BYTE), .fuse_hi(NV_FUSE_HIGH_BYTE), .flash(FLASH_RDATA));
   initial begin
      forever #2.5 CLK = ~CLK;
   end
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_compared++;
      if (g !== e) begin
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
         n_mismatch++;
      end
   endtask : chk
   task automatic give_verdict;
      $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : give_verdict
   task automatic wr(input logic [5:0] a, input logic [7:0] v);
      REG_ADDR <= a;
      REG_WDATA <= v;
      REG_WR <= 1'b1;
      @(posedge CLK);
      REG_WR <= 1'b0;
   endtask : wr
   task automatic rd(input logic [5:0] a);
      REG_ADDR <= a;
      REG_RD <= 1'b1;
      @(posedge CLK);
      REG_RD <= 1'b0;
      #1 d = REG_RDATA;
   endtask : rd
   task automatic ld(input logic [15:0] z);
      LOAD_Z <= z;
      LOAD_REQ <= 1'b1;
      @(posedge CLK);
      LOAD_REQ <= 1'b0;
      #1 chk({7'h0, LOAD_VALID}, 8'h01);
      d = LOAD_DATA;
   endtask : ld
   task automatic st(input logic [7:0] s);
      STORE_SRC <= s;
      STORE_REQ <= 1'b1;
      @(posedge CLK);
      STORE_REQ <= 1'b0;
      #1;
   endtask : st
   // bounded wait for the end-of-write pulse, n counts edges
   task automatic wait_we;
      n = 0;
      while (NV_LOCK_WE !== 1'b1 && n < 200) begin
         @(posedge CLK);
         #1 n++;
      end
      if (NV_LOCK_WE !== 1'b1) n_mismatch++;
   endtask : wait_we
   initial begin
      repeat (10) @(posedge CLK);
      RST <= 1'b0;
      #1 chk({5'h0, LOAD_VALID, LOCK_WRITE_BUSY, NV_LOCK_WE}, 8'h00);
      rd(SPC_OFF);
      chk(d, SPC_RST);
      rd(6'h3f);
      chk(d, 8'h00);
      $display("reset test done");
      foreach (rows[i]) begin
         if (rows[i].t) wr(SPC_OFF, 8'h89);
         ld(rows[i].z);
         chk(d, rows[i].e);
         @(posedge CLK);
      end
      $display("load table done");
      wr(SPC_OFF, 8'h09);
      repeat (3) @(posedge CLK);
      ld(Z_LOCK);
      chk(d, 8'ha4);
      rd(SPC_OFF);
      chk(d, 8'h00);
      $display("window expiry done");
      wr(SPC_OFF, 8'h09);
      rd(SPC_OFF);
      chk(d, 8'h09);
      st(8'hef);
      chk({7'h0, LOCK_WRITE_BUSY}, 8'h01);
      rd(SPC_OFF);
      chk(d, 8'h09);
      ld(Z_LOCK);
      chk(d, 8'ha4);
      wait_we();
      chk(n[7:0], 8'(WC));
      @(posedge CLK);
      #1 chk({1'b0, LOCK_WRITE_BUSY, NV_LOCK}, 8'h2f);
      rd(SPC_OFF);
      chk(d, 8'h00);
      $display("lock write done");
      wr(SPC_OFF, 8'h09);
      EEPROM_WRITE_BUSY <= 1'b1;
      ld(Z_LOCK);
      chk(d, 8'ha4);
      st(8'hc3);
      chk({7'h0, LOCK_WRITE_BUSY}, 8'h00);
      repeat (3) @(posedge CLK);
      wr(SPC_OFF, 8'h09);
      rd(SPC_OFF);
      chk(d, 8'h00);
      EEPROM_WRITE_BUSY <= 1'b0;
      $display("eeprom interlock done");
      @(posedge CLK);
      wr(SPC_OFF, 8'h09);
      st(8'hdf);
      repeat (3) @(posedge CLK);
      RST <= 1'b1;
      repeat (2) @(posedge CLK);
      RST <= 1'b0;
      #1 chk({7'h0, LOCK_WRITE_BUSY}, 8'h01);
      wait_we();
      @(posedge CLK);
      #1 chk({2'b0, NV_LOCK}, 8'h0f);
      wr(SPC_OFF, 8'h09);
      ld(Z_LOCK);
      chk(d, 8'hcf);
      $display("reset during write done");
      give_verdict();
   end
endmodule : tb_top
bind lfs_top lfs_assertions #(.WRITE_CYCLES(WRITE_CYCLES)) lfs_assertions_i (.CLK(CLK),
   .RST(RST), .REG_WR(REG_WR), .REG_RD(REG_RD), .LOAD_REQ(LOAD_REQ), .STORE_REQ(STORE_REQ),
   .EEPROM_WRITE_BUSY(EEPROM_WRITE_BUSY), .LOAD_VALID(LOAD_VALID), .NV_LOCK_WE(NV_LOCK_WE),
   .LOCK_WRITE_BUSY(LOCK_WRITE_BUSY), .CPU_HALT(CPU_HALT), .REG_ADDR(REG_ADDR),
   .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .FLASH_RDATA(FLASH_RDATA),
   .LOAD_DATA(LOAD_DATA), .STORE_SRC(STORE_SRC), .NV_FUSE_LOW_BYTE(NV_FUSE_LOW_BYTE),
   .NV_FUSE_HIGH_BYTE(NV_FUSE_HIGH_BYTE), .LOAD_Z(LOAD_Z), .NV_LOCK(NV_LOCK),
   .NV_LOCK_WDATA(NV_LOCK_WDATA));
`default_nettype wire
